// >>> verilog/pcrc_top.sv
// Programmable CRC generator with APB register access and word FIFO
//
// The address map and the APB interface to the registers were chosen for this implementation.
module pcrc_top
  import pcrc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              SLEEP_MODE,
  input  wire logic              IDLE_MODE,
  output logic                   CRC_EVENT
);
  if (ADDR_W < 4)
  begin : g_chk
    $error("pcrc_top: ADDR_W must be at least 4");
  end

  // Registers
  logic              sleep_meta_r, sleep_r, idle_meta_r, idle_r;
  logic              sleep_meta_nxt, sleep_nxt, idle_meta_nxt, idle_nxt;
  logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              idle_stop_r, idle_stop_nxt, go_r, go_nxt;
  logic [3:0]        length_field_r, length_field_nxt;
  logic [15:0]       tap_r, tap_nxt, crc_r, crc_nxt, stage_r, stage_nxt;
  logic [4:0]        valid_word_count_r, valid_word_count_nxt;
  logic [3:0]        wptr_r, wptr_nxt, rptr_r, rptr_nxt, bit_r, bit_nxt;
  logic              event_r, event_nxt;
  logic [15:0]       mem_r [PCRC_MEM_DEPTH];
  // Combinational terms
  logic [7:0]        addr8;
  logic              apb_wr, hit;
  logic [4:0]        depth;
  logic              full, empty, frozen, run, pop, push, rollover;
  logic              msb_lane;
  logic [15:0]       merged, step_out, head;
  logic [15:0]       ctrl_view;

  assign addr8 = 8'(PADDR);
  assign apb_wr = PSEL && PENABLE && pready_r && PWRITE;
  assign depth  = (length_field_r > PCRC_LENGTH_FIELD_BYTE_MAX) ? PCRC_DEPTH_WIDE : PCRC_DEPTH_NARROW; // RULE2
  assign full   = (valid_word_count_r == depth);                                                  // RULE3
  assign empty  = (valid_word_count_r == 5'h00);                                                  // RULE3
  assign frozen = sleep_r || (idle_r && idle_stop_r);                          // RULE18 RULE1
  assign run    = go_r && !empty && !frozen;                                   // RULE9 RULE4
  assign head   = mem_r[rptr_r];
  assign pop    = run && (bit_r == 4'h0);                                      // RULE10 RULE11
  assign msb_lane = (length_field_r > PCRC_LENGTH_FIELD_BYTE_MAX);
  assign merged = {(PSTRB[1] ? PWDATA[15:8] : stage_r[15:8]),
                   (PSTRB[0] ? PWDATA[7:0]  : stage_r[7:0])};                  // RULE7
  assign push     = apb_wr && (addr8 == PCRC_OFF_DATA) && PSTRB[msb_lane];     // RULE8
  assign rollover = push && full;                                              // RULE12

  // Control register image
  always_comb
  begin
    ctrl_view = 16'h0000;
    ctrl_view[PCRC_BIT_IDLE_STOP] = idle_stop_r;
    ctrl_view[PCRC_BIT_VALID_WORD_COUNT_LO +: PCRC_CNT_W] = valid_word_count_r;                      // RULE2
    ctrl_view[PCRC_BIT_FULL]  = full;
    ctrl_view[PCRC_BIT_EMPTY] = empty;
    ctrl_view[PCRC_BIT_GO]    = go_r;
    ctrl_view[PCRC_BIT_LENGTH_FIELD_LO +: 4] = length_field_r;
  end

  // Shift step of the CRC engine
  pcrc_step u_step (
    .crc      (crc_r),
    .taps     (tap_r),
    .length_field     (length_field_r),
    .din      (head[bit_r]),
    .crc_next (step_out)
  );

  // Power mode input synchronisers
  always_comb
  begin
    sleep_meta_nxt = SLEEP_MODE;
    sleep_nxt      = sleep_meta_r;
    idle_meta_nxt  = IDLE_MODE;
    idle_nxt       = idle_meta_r;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      sleep_meta_r <= 1'b0;
      sleep_r      <= 1'b0;
      idle_meta_r  <= 1'b0;
      idle_r       <= 1'b0;
    end
    else
    begin
      sleep_meta_r <= sleep_meta_nxt;
      sleep_r      <= sleep_nxt;
      idle_meta_r  <= idle_meta_nxt;
      idle_r       <= idle_nxt;
    end
  end

  // APB answer: ready in the first access cycle, read data captured at setup
  always_comb
  begin
    pready_nxt  = PSEL && !PENABLE && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    hit = (addr8 == PCRC_OFF_CONTROL) || (addr8 == PCRC_OFF_TAP) ||
          (addr8 == PCRC_OFF_RESULT) || (addr8 == PCRC_OFF_DATA);
    if (PSEL && !PENABLE)
    begin
      pslverr_nxt = !hit;
      prdata_nxt  = 32'h0000_0000;
      if (!PWRITE)
      begin
        case (addr8)
          PCRC_OFF_CONTROL: prdata_nxt = {16'h0000, ctrl_view};
          PCRC_OFF_TAP:     prdata_nxt = {16'h0000, tap_r[15:1], 1'b0};       // RULE6
          PCRC_OFF_RESULT:  prdata_nxt = {16'h0000, crc_r};
          PCRC_OFF_DATA:    prdata_nxt = {16'h0000, crc_r};                   // RULE15
          default:          prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA  = prdata_r;

  // Configuration, FIFO and shifter next state
  always_comb
  begin
    idle_stop_nxt = idle_stop_r;
    go_nxt    = go_r;
    length_field_nxt  = length_field_r;
    tap_nxt   = tap_r;
    crc_nxt   = crc_r;
    stage_nxt = stage_r;
    valid_word_count_nxt = valid_word_count_r;
    wptr_nxt  = wptr_r;
    rptr_nxt  = rptr_r;
    bit_nxt   = bit_r;
    if (run)
    begin
      crc_nxt = step_out;                                                     // RULE20
      bit_nxt = pop ? length_field_r : bit_r - 4'h1;                                  // RULE11
    end
    else if (empty)
    begin
      bit_nxt = length_field_r;
    end
    if (pop)
    begin
      rptr_nxt  = (rptr_r + 4'h1) & 4'(depth - 5'h01);
      valid_word_count_nxt = valid_word_count_r - 5'h01;                                            // RULE10
    end
    if (apb_wr)
    begin
      case (addr8)
        PCRC_OFF_CONTROL:
        begin
          idle_stop_nxt = PWDATA[PCRC_BIT_IDLE_STOP];
          go_nxt        = PWDATA[PCRC_BIT_GO];                                // RULE4
          length_field_nxt      = PWDATA[PCRC_BIT_LENGTH_FIELD_LO +: 4];                      // RULE5
        end
        PCRC_OFF_TAP:    tap_nxt = {PWDATA[15:1], 1'b0};                      // RULE6
        PCRC_OFF_RESULT: crc_nxt = PWDATA[15:0];
        PCRC_OFF_DATA:   stage_nxt = merged;                                  // RULE7
        default:         stage_nxt = stage_r;
      endcase
    end
    if (rollover)
    begin
      valid_word_count_nxt = 5'h00;                                                      // RULE12
      wptr_nxt  = 4'h0;
      rptr_nxt  = 4'h0;
      bit_nxt   = length_field_r;
    end
    else if (push)
    begin
      wptr_nxt  = (wptr_r + 4'h1) & 4'(depth - 5'h01);
      valid_word_count_nxt = pop ? valid_word_count_r : valid_word_count_r + 5'h01;                            // RULE8
    end
    event_nxt = (valid_word_count_r == 5'h01) && (valid_word_count_nxt == 5'h00);                   // RULE13 RULE19
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      idle_stop_r <= 1'b0;
      go_r    <= 1'b0;
      length_field_r  <= PCRC_LENGTH_FIELD_RST;
      tap_r   <= PCRC_TAP_RST;
      crc_r   <= PCRC_RESULT_RST;
      stage_r <= 16'h0000;
      valid_word_count_r <= 5'h00;
      wptr_r  <= 4'h0;
      rptr_r  <= 4'h0;
      bit_r   <= PCRC_LENGTH_FIELD_RST;
      event_r <= 1'b0;
    end
    else
    begin
      idle_stop_r <= idle_stop_nxt;
      go_r    <= go_nxt;
      length_field_r  <= length_field_nxt;
      tap_r   <= tap_nxt;
      crc_r   <= crc_nxt;
      stage_r <= stage_nxt;
      valid_word_count_r <= valid_word_count_nxt;
      wptr_r  <= wptr_nxt;
      rptr_r  <= rptr_nxt;
      bit_r   <= bit_nxt;
      event_r <= event_nxt;
    end
  end

  // FIFO storage, no reset needed
  always_ff @(posedge CLOCK)
  begin
    if (push && !rollover)
    begin
      mem_r[wptr_r] <= merged;
    end
  end

  assign CRC_EVENT = event_r;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_full_flag: assert property (full |-> valid_word_count_r == depth && !empty)          // RULE3
    else $error("full flag disagrees with count");
  a_depth_sel: assert property (valid_word_count_r <= depth)                             // RULE2
    else $error("count above FIFO depth");
  a_event_cause: assert property (CRC_EVENT |-> $past(valid_word_count_r) == 5'h01 && valid_word_count_r == 5'h00) // RULE13
    else $error("event without one to zero change");
  a_rollover_zero: assert property (rollover |=> valid_word_count_r == 5'h00 && !CRC_EVENT ##1 !CRC_EVENT) // RULE12
    else $error("write when full did not roll over");
  a_push_count: assert property (push && !rollover && !pop |=> valid_word_count_r == $past(valid_word_count_r) + 5'h01) // RULE8
    else $error("count did not increment on push");
  a_pop_count: assert property (pop && !push |=> valid_word_count_r == $past(valid_word_count_r) - 5'h01) // RULE10
    else $error("count did not decrement on pop");
  a_run_gate: assert property (run |-> go_r && valid_word_count_r != 5'h00)              // RULE9
    else $error("shifter ran without go or data");
  a_idle_continue: assert property (go_r && !empty && !sleep_r && !idle_stop_r |-> run) // RULE1
    else $error("shifter stopped in idle without stop bit");
  a_freeze_hold: assert property (frozen && !apb_wr |=> $stable(crc_r) && $stable(bit_r)) // RULE18
    else $error("state moved while frozen");
  a_word_cycles: assert property (run && bit_r == length_field_r && !apb_wr && !rollover
                                  ##1 (run && !apb_wr && !rollover)[*3] |-> length_field_r < 4'h4 || !pop) // RULE11
    else $error("word finished too early");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held more than one cycle");

  c_event: cover property (CRC_EVENT);
  c_rollover: cover property (rollover);
  c_full_wide: cover property (full && length_field_r > PCRC_LENGTH_FIELD_BYTE_MAX);
  c_freeze: cover property (frozen && go_r && !empty);
endmodule

// >>> verilog/pcrc_pkg.sv
// Constants of the programmable CRC generator
// Function
// RULE1: Idle stop bit set halts the module in Idle; clear keeps it running.
// RULE2: Valid word count shows FIFO fill; depth 8 if length above 7, else 16.
// RULE3: Full flag set at count equal depth; empty flag set at count zero.
// RULE4: Go bit one enables the serial shifter; zero keeps it off.
// RULE5: Length field is polynomial length minus one; sets CRC and word width.
// RULE6: Taps 15..1 pick middle terms; constant and 16-bit top terms implied.
// RULE7: Data write port accepts single byte writes.
// RULE8: Count increments once the word's top bit byte has been written.
// RULE9: Shifter runs only while go is one and count above zero.
// RULE10: Count decrements when a word finishes shifting; runs until count zero.
// RULE11: Each word takes length plus one cycles to shift.
// RULE12: Write while full rolls count to zero, acts empty, raises no event.
// RULE13: Count falling from one to zero raises the interrupt event.
// RULE14: Software waits one cycle after a data write before reading count.
// RULE15: Software waits for empty before reading the result.
// RULE16: Software flushes queued words by setting go until empty.
// RULE17: Software primes FIFO, sets go, then refills while count below depth.
// RULE18: Sleep freezes the module in its state and resumes afterwards.
// RULE19: Idle with stop bit acts as Sleep but still passes events.
// RULE20: One data bit per shift, top first, feedback XORed at set taps.
package pcrc_pkg;
  // Register byte offsets
  localparam logic [7:0] PCRC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] PCRC_OFF_TAP     = 8'h04;
  localparam logic [7:0] PCRC_OFF_RESULT  = 8'h08;
  localparam logic [7:0] PCRC_OFF_DATA    = 8'h0c;
  // Control field positions
  localparam int PCRC_BIT_IDLE_STOP = 13;
  localparam int PCRC_BIT_VALID_WORD_COUNT_LO  = 8;
  localparam int PCRC_BIT_FULL      = 7;
  localparam int PCRC_BIT_EMPTY     = 6;
  localparam int PCRC_BIT_GO        = 4;
  localparam int PCRC_BIT_LENGTH_FIELD_LO   = 0;
  // Widths and depths
  localparam int PCRC_W         = 16;
  localparam int PCRC_CNT_W     = 5;
  localparam int PCRC_PTR_W     = 4;
  localparam int PCRC_MEM_DEPTH = 16;
  localparam logic [4:0] PCRC_DEPTH_WIDE   = 5'h08;
  localparam logic [4:0] PCRC_DEPTH_NARROW = 5'h10;
  localparam logic [3:0] PCRC_LENGTH_FIELD_BYTE_MAX = 4'h7;
  // Reset values
  localparam logic [15:0] PCRC_TAP_RST    = 16'h0000;
  localparam logic [15:0] PCRC_RESULT_RST = 16'h0000;
  localparam logic [3:0]  PCRC_LENGTH_FIELD_RST   = 4'h0;
endpackage

// >>> verilog/pcrc_step.sv
// One shift step of the programmable CRC register
module pcrc_step
  import pcrc_pkg::*;
(
  input  wire logic [15:0] crc,
  input  wire logic [15:0] taps,
  input  wire logic [3:0]  length_field,
  input  wire logic        din,
  output logic      [15:0] crc_next
);
  logic        fb;
  logic [15:0] mask;

  // Feedback from the top stage of the active length
  always_comb
  begin
    fb   = din ^ crc[length_field];                          // RULE20
    mask = 16'hffff >> (4'hf - length_field);                // RULE5
    crc_next = 16'h0000;
    crc_next[0] = fb;                                // RULE6
    for (int i = 1; i < PCRC_W; i++)
    begin
      crc_next[i] = crc[i-1] ^ (taps[i] & fb);       // RULE6
    end
    crc_next = crc_next & mask;
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking testbench of the programmable CRC generator
module tb_top
  import pcrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} pcrc_note_type;
  logic          CLOCK = 1'b0;
  logic          RESET = 1'b1;
  logic          PSEL = 1'b0;
  logic          PENABLE = 1'b0;
  logic          PWRITE = 1'b0;
  logic [7:0]    PADDR = 8'h00;
  logic [31:0]   PWDATA = 32'h0;
  logic [3:0]    PSTRB = 4'h0;
  logic          SLEEP_MODE = 1'b0;
  logic          IDLE_MODE = 1'b0;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic          CRC_EVENT;
  int            err_count = 0;
  int            cmp_count = 0;
  int            ev_count = 0;
  int            ev_exp = 0;
  pcrc_note_type exp_q[$];
  pcrc_note_type note;

  pcrc_top #(.ADDR_W(8)) DUT (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_MODE(SLEEP_MODE), .IDLE_MODE(IDLE_MODE),
    .CRC_EVENT(CRC_EVENT));

  // Clock of 20 ns period
  always #10 CLOCK = ~CLOCK;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer, held until ready is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic e = 1'b0);
    exp_q.push_back('{32'h0, 32'h0, e});
    xfer(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = '1,
                    input logic e = 1'b0);
    exp_q.push_back('{v, m, e});
    xfer(1'b0, a, 32'h0, 4'h0);
  endtask

  // Reference CRC: top bit first, feedback into set taps and bit 0
  function automatic logic [15:0] crc_model(input logic [15:0] c, input logic [15:0] t,
                                            input logic [3:0] l, input logic [15:0] w);
    logic        fb;
    logic [16:0] msk;
    msk = (17'h1 << (l + 1)) - 17'h1;
    for (int i = 15; i >= 0; i--)
      if (i <= l)
      begin
        fb = w[i] ^ c[l];
        c = ((c << 1) | {15'h0, fb}) ^ (fb ? t : 16'h0);
        c = c & msk[15:0];
      end
    return c;
  endfunction

  // Queue words, run the shifter, optionally frozen, then check the result
  task automatic run(input logic [3:0] l, input int n, input logic sl, input logic id,
                     input logic st);
    logic [15:0] t;
    logic [15:0] c;
    logic [15:0] w;
    logic [31:0] base;
    logic [31:0] fil;
    base = {18'h0, st, 9'h0, l};
    t = 16'($urandom());
    c = 16'($urandom());
    fil = base | (32'(n) << 8) | ((l > 4'h7 ? n == 8 : n == 16) ? 32'h80 : 32'h0);
    wr(PCRC_OFF_CONTROL, base, 4'h3);
    wr(PCRC_OFF_TAP, {16'h0, t}, 4'h3);
    wr(PCRC_OFF_RESULT, {16'h0, c}, 4'h3);
    rd(PCRC_OFF_TAP, {16'h0, t & 16'hfffe});
    for (int k = 0; k < n; k++)
    begin
      w = 16'($urandom()) & 16'((17'h1 << (l + 1)) - 17'h1);
      // Low byte first; the lane holding the top bit queues the word
      wr(PCRC_OFF_DATA, {16'h0, w}, 4'h1);
      if (l > 4'h7)
        wr(PCRC_OFF_DATA, {16'h0, w}, 4'h2);
      c = crc_model(c, t & 16'hfffe, l, w);
    end
    rd(PCRC_OFF_CONTROL, fil);
    SLEEP_MODE <= sl;
    IDLE_MODE <= id;
    repeat (3) @(posedge CLOCK);
    wr(PCRC_OFF_CONTROL, base | 32'h10, 4'h3);
    if (sl | (id & st))
    begin
      repeat (40) @(posedge CLOCK);
      rd(PCRC_OFF_CONTROL, fil | 32'h10);
    end
    else
    begin
      repeat ((l + 1) * (n - 1)) @(posedge CLOCK);
      rd(PCRC_OFF_CONTROL, 32'h0, 32'h40);
    end
    SLEEP_MODE <= 1'b0;
    IDLE_MODE <= 1'b0;
    repeat ((l + 1) * n + 8) @(posedge CLOCK);
    ev_exp++;
    rd(PCRC_OFF_CONTROL, base | 32'h50);
    chk32(32'(ev_count), 32'(ev_exp));
    rd(PCRC_OFF_RESULT, {16'h0, c});
    rd(PCRC_OFF_DATA, {16'h0, c});
  endtask

  // Response watcher: oldest note against each completed transfer
  always @(posedge CLOCK)
    if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      chk32(PRDATA & note.m, note.v & note.m);
      chk32({31'h0, PSLVERR}, {31'h0, note.e});
    end

  // Event pulse counter
  always @(posedge CLOCK)
    if (CRC_EVENT === 1'b1)
      ev_count++;

  // Hang guard
  initial
  begin
    #1000000;
    err_count++;
    test_done();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32));
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    rd(PCRC_OFF_CONTROL, 32'h40);
    rd(PCRC_OFF_TAP, 32'h0);
    rd(PCRC_OFF_RESULT, 32'h0);
    rd(8'h10, 32'h0, '1, 1'b1);
    wr(8'h14, 32'hffff, 4'hf, 1'b1);
    wr(PCRC_OFF_CONTROL, 32'hffffffff, 4'hf);
    rd(PCRC_OFF_CONTROL, 32'h205f);
    run(4'hf, 8, 1'b0, 1'b0, 1'b0);
    run(4'h7, 4, 1'b0, 1'b0, 1'b1);
    run(4'h4, 2, 1'b1, 1'b0, 1'b0);
    run(4'h9, 2, 1'b0, 1'b1, 1'b1);
    run(4'h7, 3, 1'b0, 1'b1, 1'b0);
    wr(PCRC_OFF_CONTROL, 32'h3, 4'h3);
    for (int k = 0; k < 16; k++)
      wr(PCRC_OFF_DATA, $urandom() & 32'hf, 4'h1);
    rd(PCRC_OFF_CONTROL, 32'h1083);
    wr(PCRC_OFF_DATA, 32'h5, 4'h1);
    rd(PCRC_OFF_CONTROL, 32'h43);
    wr(PCRC_OFF_CONTROL, 32'h13, 4'h3);
    repeat (30) @(posedge CLOCK);
    rd(PCRC_OFF_CONTROL, 32'h53);
    chk32(32'(ev_count), 32'(ev_exp));
    repeat (4) @(posedge CLOCK);
    test_done();
  end
endmodule
